// File: whl_indicator.sv
// Purpose: status-panel indicator logic for a trackside detector
// Assumes: train summary comes from same-clock logic; pins are async
// Notes:   clk_en low freezes all state
//
// Functional notes
// RQ1 - flash balance light after 20 imbalanced trains
// RQ2 - keep flashing until both runs below 20
// RQ3 - colder scanner of pair is the faulty one
// RQ4 - balance pattern: N/E 1on2off, S/W 1on4off
// RQ5 - one balance output for bearing and wheel
// RQ6 - health flashes only if all scanners ok
// RQ7 - live echo of gating pulses during train
// RQ8 - fault light off while train present
// RQ9 - fault needs diff>=4, speed>10, odd axles
// RQ10 - fault light off, steady or flashing by history
// RQ11 - fewer hits names the faulty transducer
// RQ12 - fault patterns per transducer
// RQ13 - warning on more than 20 noise pulses
// RQ14 - warning on approach fitted but gating start
// RQ15 - ok light flashes when diff <= 3
// RQ16 - record no-approach alarm per train
// RQ17 - advance pulse opens shutters 10 seconds
// RQ18 - approach light follows track circuit signal
// RQ19 - history shifts at train end; half-second tick
`timescale 1ns/1ps
`default_nettype none

module whl_indicator #(
    parameter int HALF_SEC_CYC = whl_pkg::HALF_SEC_CYC,
    parameter int SHUTTER_CYC  = whl_pkg::SHUTTER_CYC
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    // sensor pins
    input  wire logic              train_present,
    input  wire logic              first_gating_transducer,
    input  wire logic              second_gating_transducer,
    input  wire logic              advance_a,
    input  wire logic              advance_b,
    input  wire logic              track_signal,
    // per-train result
    input  wire logic              train_end,
    input  wire whl_pkg::whl_train_t train_info,
    // indicators
    output logic                   balance_led,
    output logic                   health_led,
    output logic                   tdcr_ok_led,
    output logic                   tdcr_warn_led,
    output logic                   tdcr_fault_led,
    output logic                   approach_led,
    output logic                   shutter_open,
    output logic                   no_approach_alarm
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [5:0] pin_meta_r;
    logic [5:0] pin_sync_r;
    logic       adv_prev_r;
    logic       present_s, gate1_s, gate2_s, track_s, adv_s;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_r <= 6'h00;
            pin_sync_r <= 6'h00;
            adv_prev_r <= 1'b0;
        end else if (clk_en) begin
            pin_meta_r <= {train_present, first_gating_transducer,
                           second_gating_transducer, track_signal,
                           advance_a, advance_b};
            pin_sync_r <= pin_meta_r;
            adv_prev_r <= adv_s;
        end
    end

    assign present_s = pin_sync_r[5];
    assign gate1_s   = pin_sync_r[4];
    assign gate2_s   = pin_sync_r[3];
    assign track_s   = pin_sync_r[2];
    assign adv_s     = pin_sync_r[1] | pin_sync_r[0];

    // ****************************************************************
    // half-second time base and pattern phases
    // ****************************************************************
    logic [23:0] tick_cnt_r;
    logic        tick;
    logic [2:0]  ph_short_r, ph_long_r, ph_dbl_r;
    logic        pat_short, pat_long, pat_dbl, pat_even;

    assign tick = (tick_cnt_r == 24'(HALF_SEC_CYC - 1));

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_r <= 24'h000000;
            ph_short_r <= 3'h0;
            ph_long_r  <= 3'h0;
            ph_dbl_r   <= 3'h0;
        end else if (clk_en) begin
            tick_cnt_r <= tick ? 24'h000000 : tick_cnt_r + 24'h000001;
            if (tick) begin // RQ19
                ph_short_r <= (ph_short_r == whl_pkg::PER_SHORT - 3'h1)
                              ? 3'h0 : ph_short_r + 3'h1;
                ph_long_r  <= (ph_long_r == whl_pkg::PER_LONG - 3'h1)
                              ? 3'h0 : ph_long_r + 3'h1;
                ph_dbl_r   <= (ph_dbl_r == whl_pkg::PER_DBL - 3'h1)
                              ? 3'h0 : ph_dbl_r + 3'h1;
            end
        end
    end

    assign pat_short = (ph_short_r == 3'h0);                   // RQ4 RQ12
    assign pat_long  = (ph_long_r == 3'h0);                    // RQ4
    assign pat_dbl   = (ph_dbl_r == 3'h0) || (ph_dbl_r == 3'h2); // RQ12
    assign pat_even  = ~ph_dbl_r[0] & (ph_dbl_r != 3'h6);

    // ****************************************************************
    // per-train evaluation
    // ****************************************************************
    logic [11:0] bear_diff, wheel_diff;
    logic        bear_imb, wheel_imb, bear_low_ns, wheel_low_ns;
    logic [9:0]  hit_diff;
    logic        tf_cond;
    whl_pkg::whl_hist_t new_entry;

    always_comb begin
        bear_low_ns  = train_info.bear_n < train_info.bear_s;   // RQ3
        wheel_low_ns = train_info.wheel_n < train_info.wheel_s; // RQ3
        bear_diff  = bear_low_ns ? train_info.bear_s - train_info.bear_n
                                 : train_info.bear_n - train_info.bear_s;
        wheel_diff = wheel_low_ns ? train_info.wheel_s - train_info.wheel_n
                                  : train_info.wheel_n - train_info.wheel_s;
        bear_imb  = bear_diff > whl_pkg::BEAR_LIMIT_DC;   // RQ1
        wheel_imb = wheel_diff > whl_pkg::WHEEL_LIMIT_DC; // RQ1
        hit_diff = (train_info.hits1 > train_info.hits2)
                   ? train_info.hits1 - train_info.hits2
                   : train_info.hits2 - train_info.hits1;
        tf_cond = (hit_diff >= whl_pkg::TF_DIFF_MIN)
                  && (train_info.min_mph > whl_pkg::TF_SPEED_MPH)
                  && train_info.axles[0];                 // RQ9
        new_entry.valid = 1'b1;
        new_entry.ok    = train_info.scanners_ok;
        new_entry.tf1   = tf_cond &&
                          (train_info.hits1 < train_info.hits2); // RQ11
        new_entry.tf2   = tf_cond &&
                          (train_info.hits2 < train_info.hits1); // RQ11
        new_entry.warn  = (train_info.noise1 > whl_pkg::NOISE_LIMIT)
                          || (train_info.noise2 > whl_pkg::NOISE_LIMIT) // RQ13
                          || (train_info.approach_fitted
                              && train_info.started_by_gating);         // RQ14
    end

    // ****************************************************************
    // train history and imbalance runs
    // ****************************************************************
    whl_pkg::whl_hist_t hist_r [whl_pkg::HIST_DEPTH];
    logic [4:0] bear_run_r, wheel_run_r;
    logic       bear_ns_r, wheel_ns_r, last_ok_diff_r;
    logic [whl_pkg::HIST_DEPTH-1:0] h_ok, h_tf1, h_tf2, h_warn;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < whl_pkg::HIST_DEPTH; i++) begin
                hist_r[i] <= '0;
            end
        end else if (clk_en && train_end) begin
            hist_r[0] <= new_entry; // RQ19
            for (int i = 1; i < whl_pkg::HIST_DEPTH; i++) begin
                hist_r[i] <= hist_r[i-1];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bear_run_r        <= 5'h00;
            wheel_run_r       <= 5'h00;
            bear_ns_r         <= 1'b0;
            wheel_ns_r        <= 1'b0;
            last_ok_diff_r    <= 1'b0;
            no_approach_alarm <= 1'b0;
        end else if (clk_en && train_end) begin
            if (!bear_imb) begin
                bear_run_r <= 5'h00;
            end else if (bear_run_r != 5'(whl_pkg::RUN_LIMIT)) begin
                bear_run_r <= bear_run_r + 5'h01; // RQ1
            end
            if (!wheel_imb) begin
                wheel_run_r <= 5'h00;
            end else if (wheel_run_r != 5'(whl_pkg::RUN_LIMIT)) begin
                wheel_run_r <= wheel_run_r + 5'h01; // RQ1
            end
            bear_ns_r      <= bear_low_ns;  // RQ3
            wheel_ns_r     <= wheel_low_ns; // RQ3
            last_ok_diff_r <= hit_diff <= whl_pkg::OK_DIFF_MAX; // RQ15
            no_approach_alarm <= !train_info.approach_seen
                                 && train_info.started_by_gating; // RQ16
        end
    end

    for (genvar g = 0; g < whl_pkg::HIST_DEPTH; g++) begin : g_hist
        assign h_ok[g]   = hist_r[g].ok | ~hist_r[g].valid;
        assign h_tf1[g]  = hist_r[g].tf1;
        assign h_tf2[g]  = hist_r[g].tf2;
        assign h_warn[g] = hist_r[g].warn;
    end

    // ****************************************************************
    // indicator drive
    // ****************************************************************
    logic bear_flag, wheel_flag, rail_ns, rail_sw, health_all, any1, any2;
    logic shut_load;
    logic [27:0] shut_cnt_r;

    assign bear_flag  = bear_run_r == 5'(whl_pkg::RUN_LIMIT);  // RQ2
    assign wheel_flag = wheel_run_r == 5'(whl_pkg::RUN_LIMIT); // RQ2
    assign rail_ns = (bear_flag & bear_ns_r) | (wheel_flag & wheel_ns_r); // RQ5
    assign rail_sw = (bear_flag & ~bear_ns_r)
                     | (wheel_flag & ~wheel_ns_r);              // RQ5
    assign health_all = hist_r[0].valid & (&h_ok);              // RQ6
    assign any1 = |h_tf1;
    assign any2 = |h_tf2;
    assign shut_load = adv_s & ~adv_prev_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            balance_led    <= 1'b0;
            health_led     <= 1'b0;
            tdcr_ok_led    <= 1'b0;
            tdcr_warn_led  <= 1'b0;
            tdcr_fault_led <= 1'b0;
            approach_led   <= 1'b0;
        end else if (clk_en) begin
            balance_led <= rail_ns ? pat_short
                                   : (rail_sw & pat_long);     // RQ4
            health_led  <= health_all & pat_even;              // RQ6
            approach_led <= track_s;                           // RQ18
            if (present_s) begin
                tdcr_ok_led    <= gate1_s;                     // RQ7
                tdcr_warn_led  <= gate2_s;                     // RQ7
                tdcr_fault_led <= 1'b0;                        // RQ8
            end else begin
                tdcr_ok_led   <= last_ok_diff_r & pat_even;    // RQ15
                tdcr_warn_led <= |h_warn;                      // RQ13 RQ14
                if (any1 && any2) begin
                    tdcr_fault_led <= 1'b1;                    // RQ10
                end else if (any1) begin
                    tdcr_fault_led <= pat_short;               // RQ12
                end else begin
                    tdcr_fault_led <= any2 & pat_dbl;          // RQ12
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shut_cnt_r   <= 28'h0000000;
            shutter_open <= 1'b0;
        end else if (clk_en) begin
            if (shut_load) begin
                shut_cnt_r   <= 28'(SHUTTER_CYC - 1);          // RQ17
                shutter_open <= 1'b1;
            end else if (shut_cnt_r != 28'h0000000) begin
                shut_cnt_r <= shut_cnt_r - 28'h0000001;
            end else begin
                shutter_open <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_adv_edge;
        clk_en && shut_load;
    endsequence

    sequence s_open_hold;
        shutter_open [*8];
    endsequence

    AST_BAL_CAUSE: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && $rose(balance_led) |-> $past(bear_flag || wheel_flag)) // RQ1
        else $error("balance light without 20 imbalanced trains");

    AST_BAL_DROP: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && !bear_flag && !wheel_flag |=> !balance_led) // RQ2
        else $error("balance light on after runs dropped");

    AST_HEALTH: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && !health_all |=> !health_led) // RQ6
        else $error("health light on with a scanner fault");

    AST_LIVE: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && present_s |=> tdcr_ok_led == $past(gate1_s)
                                && tdcr_warn_led == $past(gate2_s)) // RQ7
        else $error("gating pulses not echoed during train");

    AST_FAULT_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && present_s |=> !tdcr_fault_led) // RQ8
        else $error("fault light on while train present");

    AST_FAULT_STEADY: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        clk_en && !present_s && any1 && any2 |=> tdcr_fault_led) // RQ10
        else $error("fault light not steady with both transducers");

    AST_TF_ATTR: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && train_end && tf_cond
        && train_info.hits1 < train_info.hits2 |=> hist_r[0].tf1
                                                && !hist_r[0].tf2) // RQ11
        else $error("fault not charged to transducer with fewer hits");

    AST_SHUTTER: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_adv_edge ##1 clk_en [*1] |-> s_open_hold) // RQ17
        else $error("shutters not held open after advance pulse");

    AST_APPROACH: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en ##1 clk_en |-> approach_led == $past(track_s)) // RQ18
        else $error("approach light does not follow track signal");

endmodule // whl_indicator

`default_nettype wire

// File: whl_pkg.sv
// Purpose: shared constants and types for the wayside health indicators
// Assumes: 25 MHz core clock; temperatures in tenths of a degree Celsius
// Notes:   counts and speeds are unsigned binary
package whl_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int HALF_SEC_NS   = 500_000_000;
    localparam int HALF_SEC_CYC  = HALF_SEC_NS / CLK_PERIOD_NS;
    localparam int SHUTTER_S     = 10;
    localparam int SHUTTER_CYC   = SHUTTER_S * (1_000_000_000 / CLK_PERIOD_NS);

    // ****************************************************************
    // history and limits
    // ****************************************************************
    localparam int         HIST_DEPTH     = 20;
    localparam int         RUN_LIMIT      = 20;
    localparam logic [11:0] BEAR_LIMIT_DC = 12'h01C;   // 2.8 C
    localparam logic [11:0] WHEEL_LIMIT_DC = 12'h053;  // 8.3 C
    localparam logic [9:0] TF_DIFF_MIN    = 10'h004;
    localparam logic [9:0] OK_DIFF_MAX    = 10'h003;
    localparam logic [7:0] TF_SPEED_MPH   = 8'h0A;
    localparam logic [7:0] NOISE_LIMIT    = 8'h14;

    // ****************************************************************
    // flash pattern periods in half-second steps
    // ****************************************************************
    localparam logic [2:0] PER_SHORT = 3'h3;   // on 1, off 2
    localparam logic [2:0] PER_LONG  = 3'h5;   // on 1, off 4
    localparam logic [2:0] PER_DBL   = 3'h7;   // on, off, on, off 4

    // per-train summary delivered at end of train
    typedef struct packed {
        logic [11:0] bear_n;
        logic [11:0] bear_s;
        logic [11:0] wheel_n;
        logic [11:0] wheel_s;
        logic        scanners_ok;
        logic [9:0]  axles;
        logic [9:0]  hits1;
        logic [9:0]  hits2;
        logic [7:0]  min_mph;
        logic [7:0]  noise1;
        logic [7:0]  noise2;
        logic        approach_fitted;
        logic        started_by_gating;
        logic        approach_seen;
    } whl_train_t;

    // one history entry
    typedef struct packed {
        logic valid;
        logic ok;
        logic tf1;
        logic tf2;
        logic warn;
    } whl_hist_t;

endpackage

// File: whl_sensor_model.sv
// Purpose: sensor front-end model for the indicator bench
// Assumes: driven just after the rising edge of core_clk
// Notes:   summary bus carries inverted junk outside its pulse
`timescale 1ns/1ps
`default_nettype none

module whl_sensor_model (
    // clock
    input  wire logic          core_clk,
    // pins: present, gate 1, gate 2, advance a, advance b, track
    output logic [5:0]         pins,
    // train result
    output logic               train_end,
    output whl_pkg::whl_train_t train_info
);
    initial begin
        pins       = 6'h00;
        train_end  = 1'b0;
        train_info = '0;
    end

    // ****************************************************************
    // stimulus tasks
    // ****************************************************************
    task automatic send(input whl_pkg::whl_train_t t);
        @(posedge core_clk);
        #1;
        train_info = t;
        train_end  = 1'b1;
        @(posedge core_clk);
        #1;
        train_end  = 1'b0;
        train_info = ~t;
    endtask

    task automatic pin(input int k, input logic v);
        @(posedge core_clk);
        #1;
        pins[k] = v;
    endtask
endmodule // whl_sensor_model

`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the wayside indicator block
// Assumes: half-second tick scaled to 4 cycles, shutter time to 20
// Notes:   flash patterns judged by lit cycles over a 420-cycle window
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int HS  = 4;
    localparam int SH  = 20;
    localparam int WIN = 420;
    localparam int BAL = 0;
    localparam int HLT = 1;
    localparam int OKL = 2;
    localparam int WRN = 3;
    localparam int FLT = 4;
    localparam int APR = 5;
    localparam int SHT = 6;
    localparam int ALM = 7;

    logic                core_clk;
    logic                arst_n;
    logic                clk_en;
    wire [5:0]           pins;
    wire                 train_end;
    whl_pkg::whl_train_t train_info;
    whl_pkg::whl_train_t t;
    wire [7:0]           leds;
    int                  err_count;
    int                  checked;
    int                  cycles;

    // ****************************************************************
    // clock, partner and design
    // ****************************************************************
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    whl_sensor_model i_whl_sensor_model (
        .core_clk(core_clk), .pins(pins),
        .train_end(train_end), .train_info(train_info));

    whl_indicator #(.HALF_SEC_CYC(HS), .SHUTTER_CYC(SH)) i_whl_indicator (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
        .train_present(pins[0]), .first_gating_transducer(pins[1]),
        .second_gating_transducer(pins[2]), .advance_a(pins[3]),
        .advance_b(pins[4]), .track_signal(pins[5]),
        .train_end(train_end), .train_info(train_info),
        .balance_led(leds[0]), .health_led(leds[1]),
        .tdcr_ok_led(leds[2]), .tdcr_warn_led(leds[3]),
        .tdcr_fault_led(leds[4]), .approach_led(leds[5]),
        .shutter_open(leds[6]), .no_approach_alarm(leds[7]));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic lvl(input int k, input logic v);
        repeat (4) @(posedge core_clk);
        #1;
        chk(leds[k], v);
    endtask

    // lit cycles of one light over the window
    task automatic look(input int k, input int exp);
        int n;
        n = 0;
        repeat (3) @(posedge core_clk);
        repeat (WIN) begin
            @(posedge core_clk);
            #1;
            if (leds[k] === 1'b1) n++;
        end
        chk(n, exp);
    endtask

    task automatic base;
        t = '0;
        t.bear_n = 12'h100;
        t.bear_s = 12'h100;
        t.wheel_n = 12'h200;
        t.wheel_s = 12'h200;
        t.scanners_ok = 1'b1;
        t.axles = 10'h00C;
        t.hits1 = 10'h00C;
        t.hits2 = 10'h00C;
        t.min_mph = 8'h32;
    endtask

    task automatic tx(input int n);
        repeat (n) i_whl_sensor_model.send(t);
    endtask

    task automatic gt(input logic [9:0] h1, input logic [9:0] h2,
                      input logic [9:0] ax, input logic [7:0] mph);
        base;
        t.hits1 = h1;
        t.hits2 = h2;
        t.axles = ax;
        t.min_mph = mph;
        tx(1);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_pins;
        i_whl_sensor_model.pin(5, 1'b1);
        lvl(APR, 1'b1);
        i_whl_sensor_model.pin(5, 1'b0);
        lvl(APR, 1'b0);
        for (int k = 3; k < 5; k++) begin
            i_whl_sensor_model.pin(k, 1'b1);
            i_whl_sensor_model.pin(k, 1'b0);
            repeat (3) @(posedge core_clk);
            #1;
            chk(leds[SHT], 1'b1);
            repeat (18) @(posedge core_clk);
            #1;
            chk(leds[SHT], 1'b1);
            repeat (6) @(posedge core_clk);
            #1;
            chk(leds[SHT], 1'b0);
        end
    endtask

    task automatic t_balance;
        base;
        t.bear_s = 12'h11D;
        t.wheel_s = 12'h253;
        tx(19);
        look(BAL, 0);
        tx(1);
        look(BAL, 140);
        base;
        tx(1);
        look(BAL, 0);
        t.wheel_n = 12'h254;
        tx(20);
        look(BAL, 84);
        base;
        tx(1);
        look(BAL, 0);
    endtask

    task automatic t_health;
        base;
        tx(20);
        look(HLT, 180);
        t.scanners_ok = 1'b0;
        tx(1);
        look(HLT, 0);
    endtask

    task automatic t_fault;
        gt(10'h008, 10'h00C, 10'h00C, 8'h32);
        gt(10'h00D, 10'h00A, 10'h00D, 8'h32);
        gt(10'h009, 10'h00D, 10'h00D, 8'h0A);
        look(FLT, 0);
        gt(10'h009, 10'h00D, 10'h00D, 8'h0B);
        look(FLT, 140);
        base;
        tx(19);
        look(FLT, 140);
        tx(1);
        look(FLT, 0);
        gt(10'h00D, 10'h009, 10'h00D, 8'h32);
        look(FLT, 120);
        gt(10'h009, 10'h00D, 10'h00D, 8'h32);
        look(FLT, WIN);
    endtask

    task automatic t_warn;
        gt(10'h00A, 10'h00D, 10'h00B, 8'h05);
        look(OKL, 180);
        gt(10'h008, 10'h00C, 10'h00C, 8'h05);
        look(OKL, 0);
        base;
        tx(20);
        lvl(WRN, 1'b0);
        t.noise2 = 8'h14;
        tx(1);
        lvl(WRN, 1'b0);
        t.noise1 = 8'h15;
        tx(1);
        lvl(WRN, 1'b1);
        base;
        tx(20);
        lvl(WRN, 1'b0);
        t.approach_fitted = 1'b1;
        t.started_by_gating = 1'b1;
        tx(1);
        lvl(WRN, 1'b1);
        chk(leds[ALM], 1'b1);
        t.approach_seen = 1'b1;
        t.started_by_gating = 1'b0;
        tx(1);
        lvl(ALM, 1'b0);
    endtask

    task automatic t_live;
        gt(10'h009, 10'h00D, 10'h00D, 8'h32);
        i_whl_sensor_model.pin(0, 1'b1);
        lvl(FLT, 1'b0);
        i_whl_sensor_model.pin(1, 1'b1);
        lvl(OKL, 1'b1);
        chk(leds[WRN], 1'b0);
        i_whl_sensor_model.pin(1, 1'b0);
        i_whl_sensor_model.pin(2, 1'b1);
        lvl(WRN, 1'b1);
        chk(leds[OKL], 1'b0);
        i_whl_sensor_model.pin(2, 1'b0);
        i_whl_sensor_model.pin(0, 1'b0);
        look(FLT, 140);
    endtask

    // enable low must freeze the pin path, then release it
    task automatic t_freeze;
        @(posedge core_clk);
        #1;
        clk_en = 1'b0;
        i_whl_sensor_model.pin(5, 1'b1);
        lvl(APR, 1'b0);
        @(posedge core_clk);
        #1;
        clk_en = 1'b1;
        lvl(APR, 1'b1);
        i_whl_sensor_model.pin(5, 1'b0);
        lvl(APR, 1'b0);
    endtask

    // ****************************************************************
    // main sequence and hang guard
    // ****************************************************************
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up;
        end
    end

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        err_count = 0;
        checked = 0;
        cycles = 0;
        t = '0;
        repeat (10) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        @(posedge core_clk);
        #1;
        chk(leds, 8'h00);
        t_pins;
        t_balance;
        t_health;
        t_fault;
        t_warn;
        t_live;
        t_freeze;
        wrap_up;
    end
endmodule // tb_top

`default_nettype wire
